// ### bench/stc_timer_assertions.sv
/*
 * stc_timer_assertions: port-level checks for the 16-bit timer/counter.
 * Assumes one clock, active-low async reset, and a bind to stc_timer.
 */
`timescale 1ns/1ns
module stc_timer_assertions
	import stc_pkg::*;
(
	input wire logic       clock,
	input wire logic       resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_write,
	input wire logic       reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic       global_irq_enable,
	input wire logic       cmp_vector_taken,
	input wire logic       ovf_vector_taken,
	input wire logic       cmp_irq,
	input wire logic       ovf_irq,
	input wire logic       compare_match_pulse
);
	// ****************************************
	// port relations
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	// read data only in the cycle after a read strobe
	chk_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	chk_upper_zero: assert property ((reg_read && (reg_addr == STC_ADDR_IRQ_MASK ||
		reg_addr == STC_ADDR_IRQ_FLAGS)) |=> reg_rdata[7:2] == 6'h00) else $error("upper bits not zero");
	// requests need the global enable
	chk_cmp_gate: assert property (!global_irq_enable |=> !cmp_irq)
		else $error("compare irq without global enable");
	chk_ovf_gate: assert property (!global_irq_enable |=> !ovf_irq)
		else $error("overflow irq without global enable");
	chk_cmp_rise: assert property ($rose(cmp_irq) |-> $past(global_irq_enable))
		else $error("compare irq rose while disabled");
	// clears by vector or by writing one
	chk_cmp_clear: assert property (cmp_vector_taken |=> !cmp_irq)
		else $error("compare vector did not clear");
	chk_ovf_clear: assert property (ovf_vector_taken |=> !ovf_irq)
		else $error("overflow vector did not clear");
	chk_flag_w1c: assert property ((reg_write && reg_addr == STC_ADDR_IRQ_FLAGS && reg_wdata[1]) |=> !cmp_irq)
		else $error("write one did not clear");
	// sticky flags hold the request until cleared
	chk_cmp_hold: assert property ((cmp_irq && global_irq_enable && !cmp_vector_taken && !reg_write) |=> cmp_irq)
		else $error("compare irq dropped");
	chk_ovf_hold: assert property ((ovf_irq && global_irq_enable && !ovf_vector_taken && !reg_write) |=> ovf_irq)
		else $error("overflow irq dropped");

	cover property (cmp_irq);
	cover property (ovf_irq);
	cover property (compare_match_pulse);
endmodule

bind stc_timer stc_timer_assertions chk_u (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.global_irq_enable(global_irq_enable), .cmp_vector_taken(cmp_vector_taken),
	.ovf_vector_taken(ovf_vector_taken), .cmp_irq(cmp_irq), .ovf_irq(ovf_irq),
	.compare_match_pulse(compare_match_pulse));

// ### bench/stc_timer_tb_top.sv
/*
 * stc_timer_tb_top: self-checking bench for the 16-bit timer/counter.
 * Assumes the register port contract with read data one cycle after strobe.
 */
`timescale 1ns/1ns
module stc_timer_tb_top
	import stc_pkg::*;
;
	logic        clock = 1'b0;
	logic        resetn, reg_write, reg_read, global_irq_enable, cmp_vector_taken, ovf_vector_taken;
	logic        cmp_irq, ovf_irq, compare_match_pulse;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, got;
	logic [15:0] cnt;
	logic [7:0]  row_a [5] = '{STC_ADDR_IRQ_MASK, STC_ADDR_IRQ_FLAGS, STC_ADDR_CONTROL_A, STC_ADDR_CONTROL_B, 8'h00};
	logic [7:0]  row_d [5] = '{8'hff, 8'hff, 8'hff, 8'h0f, 8'h55};
	logic [7:0]  row_e [5] = '{8'h03, 8'h00, 8'h03, 8'h0f, 8'h00};
	int          shift [5] = '{0, 3, 6, 8, 10};
	int          failures, samples_checked, i, n;

	// 50 MHz clock
	always #10 clock = ~clock;

	stc_timer dut_u (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.global_irq_enable(global_irq_enable), .cmp_vector_taken(cmp_vector_taken),
		.ovf_vector_taken(ovf_vector_taken), .cmp_irq(cmp_irq), .ovf_irq(ovf_irq),
		.compare_match_pulse(compare_match_pulse));

	// ****************************************
	// bus and compare tasks
	// ****************************************
	task chk(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	// sampled just after the edge that loads read data
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// low byte first on reads, high byte first on writes
	task rd16(input logic [7:0] a, output logic [15:0] v);
		rd(a, v[7:0]);
		rd(a + 8'h01, v[15:8]);
	endtask
	task wr16(input logic [7:0] a, input logic [15:0] v);
		wr(a + 8'h01, v[15:8]);
		wr(a, v[7:0]);
	endtask
	task pulse_vec(input logic cmp);
		@(posedge clock);
		cmp_vector_taken <= cmp;
		ovf_vector_taken <= !cmp;
		@(posedge clock);
		cmp_vector_taken <= 1'b0;
		ovf_vector_taken <= 1'b0;
		#1;
	endtask
	task give_verdict;
		$display("failures=%0d samples_checked=%0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{resetn, reg_write, reg_read, global_irq_enable, cmp_vector_taken, ovf_vector_taken} = 6'h00;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		// reset value, then write and read back
		for (i = 0; i < 5; i++) begin
			rd(row_a[i], got);
			chk(got, 8'h00);
			wr(row_a[i], row_d[i]);
			rd(row_a[i], got);
			chk(got, row_e[i]);
		end
		wr(STC_ADDR_CONTROL_A, 8'h00);
		wr(STC_ADDR_CONTROL_B, 8'h00);
		wr16(STC_ADDR_COUNT_LOW, 16'h1234);
		rd16(STC_ADDR_COUNT_LOW, cnt);
		chk(cnt, 16'h1234);
		wr16(STC_ADDR_CMP_LOW, 16'habcd);
		rd16(STC_ADDR_CMP_LOW, cnt);
		chk(cnt, 16'habcd);
		wr(STC_ADDR_FORCE, 8'h80);
		#1 chk(compare_match_pulse, 1'b1);
		rd(STC_ADDR_IRQ_FLAGS, got);
		chk(got, 8'h00);
		wr(STC_ADDR_CONTROL_B, 8'h06);
		repeat (20) @(posedge clock);
		wr(STC_ADDR_CONTROL_B, 8'h07);
		repeat (20) @(posedge clock);
		rd16(STC_ADDR_COUNT_LOW, cnt);
		chk(cnt, 16'h1234);
		// every divider over a 2048-cycle window
		for (i = 1; i < 6; i++) begin
			wr16(STC_ADDR_COUNT_LOW, 16'h0000);
			wr(STC_ADDR_CONTROL_B, 8'(i));
			repeat (2048) @(posedge clock);
			wr(STC_ADDR_CONTROL_B, 8'h00);
			rd16(STC_ADDR_COUNT_LOW, cnt);
			chk(cnt >= (2048 >> shift[i-1]) && cnt <= (2048 >> shift[i-1]) + 3, 1'b1);
		end
		// normal mode overflow
		global_irq_enable <= 1'b1;
		wr16(STC_ADDR_COUNT_LOW, 16'hfff0);
		wr(STC_ADDR_IRQ_FLAGS, 8'h03);
		wr(STC_ADDR_CONTROL_B, 8'h01);
		for (n = 0; n < 40 && ovf_irq !== 1'b1; n++) begin
			@(posedge clock);
			#1;
		end
		chk(ovf_irq, 1'b1);
		wr(STC_ADDR_CONTROL_B, 8'h00);
		rd16(STC_ADDR_COUNT_LOW, cnt);
		chk(cnt < 16'h0020, 1'b1);
		pulse_vec(1'b0);
		chk(ovf_irq, 1'b0);
		// clear-on-match with the global enable off
		global_irq_enable <= 1'b0;
		wr16(STC_ADDR_CMP_LOW, 16'h0010);
		wr16(STC_ADDR_COUNT_LOW, 16'h0000);
		wr(STC_ADDR_CONTROL_B, 8'h09);
		repeat (60) @(posedge clock);
		chk(cmp_irq, 1'b0);
		wr(STC_ADDR_CONTROL_B, 8'h08);
		rd(STC_ADDR_IRQ_FLAGS, got);
		chk(got, 8'h02);
		rd16(STC_ADDR_COUNT_LOW, cnt);
		chk(cnt <= 16'h0010, 1'b1);
		global_irq_enable <= 1'b1;
		@(posedge clock);
		#1 chk(cmp_irq, 1'b1);
		pulse_vec(1'b1);
		chk(cmp_irq, 1'b0);
		wr(STC_ADDR_CONTROL_B, 8'h09);
		repeat (40) @(posedge clock);
		wr(STC_ADDR_CONTROL_B, 8'h08);
		repeat (3) @(posedge clock);
		#1 chk(cmp_irq, 1'b1);
		wr(STC_ADDR_IRQ_FLAGS, 8'h02);
		#1 chk(cmp_irq, 1'b0);
		// counter written to the compare value: next match suppressed
		wr(STC_ADDR_CONTROL_B, 8'h00);
		wr16(STC_ADDR_CMP_LOW, 16'h0030);
		wr16(STC_ADDR_COUNT_LOW, 16'h0030);
		wr(STC_ADDR_CONTROL_B, 8'h01);
		repeat (10) @(posedge clock);
		wr(STC_ADDR_CONTROL_B, 8'h00);
		rd(STC_ADDR_IRQ_FLAGS, got);
		chk(got, 8'h00);
		give_verdict();
	end

	// watchdog: about three and a half times the expected run
	initial begin
		#750000;
		failures++;
		give_verdict();
	end
endmodule

// ### logic/stc_pkg.sv
/*
 * stc_pkg: constants for the 16-bit timer/counter: register offsets, field
 * positions, reset values, mode and clock-select codes, prescaler ratios.
 * Assumes an 8-bit register port with byte offsets as printed.
 */
package stc_pkg;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] STC_ADDR_IRQ_FLAGS  = 8'h16;
	localparam logic [7:0] STC_ADDR_IRQ_MASK   = 8'h6f;
	localparam logic [7:0] STC_ADDR_CONTROL_A  = 8'h80;
	localparam logic [7:0] STC_ADDR_CONTROL_B  = 8'h81;
	localparam logic [7:0] STC_ADDR_COUNT_LOW  = 8'h84;
	localparam logic [7:0] STC_ADDR_COUNT_HIGH = 8'h85;
	localparam logic [7:0] STC_ADDR_CMP_LOW    = 8'h88;
	localparam logic [7:0] STC_ADDR_CMP_HIGH   = 8'h89;
	// own choice: force-compare strobe register
	localparam logic [7:0] STC_ADDR_FORCE      = 8'h82;

	// ****************************************
	// field positions
	// ****************************************
	localparam int STC_BIT_OVF          = 0;
	localparam int STC_BIT_CMP          = 1;
	localparam int STC_BIT_WAVE_MODE2   = 3;
	localparam int STC_BIT_FORCE_CMP    = 7;

	// ****************************************
	// reset values and count maximum
	// ****************************************
	localparam logic [7:0]  STC_RESET_BYTE  = 8'h00;
	localparam logic [15:0] STC_RESET_WORD  = 16'h0000;
	localparam logic [15:0] STC_COUNT_MAX   = 16'hffff;

	// ****************************************
	// mode and clock-select codes
	// ****************************************
	localparam logic [2:0] STC_MODE_NORMAL = 3'h0;
	localparam logic [2:0] STC_MODE_CLEAR  = 3'h4;

	localparam logic [2:0] STC_CS_STOP  = 3'h0;
	localparam logic [2:0] STC_CS_DIV1  = 3'h1;
	localparam logic [2:0] STC_CS_DIV8  = 3'h2;
	localparam logic [2:0] STC_CS_DIV64 = 3'h3;
	localparam logic [2:0] STC_CS_DIV256  = 3'h4;
	localparam logic [2:0] STC_CS_DIV1024 = 3'h5;

	// prescaler tap masks: low bits all ones once per divided period
	localparam logic [9:0] STC_PRE_MASK8    = 10'h007;
	localparam logic [9:0] STC_PRE_MASK64   = 10'h03f;
	localparam logic [9:0] STC_PRE_MASK256  = 10'h0ff;
	localparam logic [9:0] STC_PRE_MASK1024 = 10'h3ff;

endpackage

// ### logic/stc_timer.sv
/*
 * stc_timer: 16-bit timer/counter with control, count, compare, mask and
 * flag registers reached over a plain strobe port with registered read data.
 * Assumes one 50 MHz clock, the global interrupt enable and vector-taken
 * acknowledges arrive from the core on the same clock.
 */
`timescale 1ns/1ns

// ****************************************
// usage notes
// ****************************************
// register port:
//   strobes are single-cycle and never both high
//   no wait states; read data registered, one cycle later
//   read data is zero in every other cycle
//   unmapped offsets ignore writes and read as zero
// sixteen-bit access:
//   write high byte first; it only lands in temp
//   low byte write then loads the whole word
//   read low byte first; it copies high into temp
//   one temp for counter and compare, so a handler
//   touching either pair can spoil a split access
// counter:
//   prescaler free-running and shared by all dividers,
//   so the first divided tick after enabling comes early
//   reserved clock-select codes hold the counter still
//   reserved wave modes count like normal mode
//   a high-byte write alone never stalls counting
//   a low-byte write blocks the match at the next tick,
//   even while stopped, so compare may equal count safely
// flags:
//   sticky until vector acknowledge or write of one
//   a set in the same cycle as a clear wins
//   requests registered from the next flag value,
//   so they rise in the cycle the flag rises
// forced compare:
//   own offset, bit 7; pulses the match output only
//   never touches the compare flag
//   other bits written there are ignored
// limitations:
//   no pwm modes, no output pin waveform logic
//   no prescaler reset; dividers share one free counter

module stc_timer
	import stc_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	output logic      [7:0] reg_rdata,
	input  wire logic       global_irq_enable,
	input  wire logic       cmp_vector_taken,
	input  wire logic       ovf_vector_taken,
	output logic            cmp_irq,
	output logic            ovf_irq,
	output logic            compare_match_pulse
);

	// ****************************************
	// registers
	// ****************************************
	logic [1:0]  ctrl_a_q;
	logic [3:0]  ctrl_b_q;
	logic [1:0]  mask_q;
	logic [1:0]  flags_q;
	logic [1:0]  flags_d;
	logic [15:0] count_q;
	logic [15:0] count_d;
	logic [15:0] cmp_q;
	logic [7:0]  temp_q;
	logic [7:0]  temp_d;
	logic [9:0]  pre_q;
	logic        block_q;
	logic        block_d;
	logic        match_q;
	logic        cmp_irq_q;
	logic        ovf_irq_q;
	logic        fire_q;
	logic [7:0]  rdata_q;
	logic [7:0]  rdata_d;

	// ****************************************
	// decode
	// ****************************************
	wire logic [2:0] clock_select = ctrl_b_q[2:0];
	wire logic [2:0] wave_mode    = {ctrl_b_q[STC_BIT_WAVE_MODE2], ctrl_a_q};
	wire logic       clear_on_match_mode = (wave_mode == STC_MODE_CLEAR);
	wire logic       wr_count_low  = reg_write && (reg_addr == STC_ADDR_COUNT_LOW);
	wire logic       wr_count_high = reg_write && (reg_addr == STC_ADDR_COUNT_HIGH);
	wire logic       wr_cmp_low    = reg_write && (reg_addr == STC_ADDR_CMP_LOW);
	wire logic       wr_cmp_high   = reg_write && (reg_addr == STC_ADDR_CMP_HIGH);
	wire logic       wr_flags      = reg_write && (reg_addr == STC_ADDR_IRQ_FLAGS);
	wire logic       rd_count_low  = reg_read && (reg_addr == STC_ADDR_COUNT_LOW);
	wire logic       rd_cmp_low    = reg_read && (reg_addr == STC_ADDR_CMP_LOW);
	wire logic       forced_compare_strobe = reg_write && (reg_addr == STC_ADDR_FORCE)
	                                         && reg_wdata[STC_BIT_FORCE_CMP];

	// prescaler tick select; reserved codes give no tick
	function automatic logic tick_of(input logic [2:0] cs, input logic [9:0] pre);
		logic t;
		t = 1'b0;
		case (cs)
			STC_CS_DIV1:    t = 1'b1;
			STC_CS_DIV8:    t = ((pre & STC_PRE_MASK8) == STC_PRE_MASK8);
			STC_CS_DIV64:   t = ((pre & STC_PRE_MASK64) == STC_PRE_MASK64);
			STC_CS_DIV256:  t = ((pre & STC_PRE_MASK256) == STC_PRE_MASK256);
			STC_CS_DIV1024: t = ((pre & STC_PRE_MASK1024) == STC_PRE_MASK1024);
			default:        t = 1'b0;
		endcase
		return t;
	endfunction

	wire logic timer_tick = tick_of(clock_select, pre_q);
	wire logic equal_now  = (count_q == cmp_q);
	wire logic count_write = wr_count_low;

	// ****************************************
	// counter next value
	// ****************************************
	// cpu write first, then clear-on-match, then increment
	always_comb begin
		count_d = count_q;
		if (count_write) begin
			count_d = {temp_q, reg_wdata};
		end else if (timer_tick) begin
			if (clear_on_match_mode && equal_now) begin
				count_d = STC_RESET_WORD;
			end else begin
				count_d = count_q + 16'h0001;
			end
		end
	end

	// overflow when stepping from max, in either supported mode
	wire logic wrap_now = timer_tick && !count_write && (count_q == STC_COUNT_MAX)
	                      && !(clear_on_match_mode && equal_now);
	// match seen at a tick becomes the flag; a blocked tick never counts
	wire logic match_set = match_q;
	wire logic raw_match = timer_tick && equal_now && !block_q && !count_write;

	// ****************************************
	// flags, blocking, temp
	// ****************************************
	// set beats clear so no event is lost
	always_comb begin
		flags_d = flags_q;
		if (wr_flags) begin
			flags_d = flags_q & ~reg_wdata[1:0];
		end
		if (cmp_vector_taken) begin
			flags_d[STC_BIT_CMP] = 1'b0;
		end
		if (ovf_vector_taken) begin
			flags_d[STC_BIT_OVF] = 1'b0;
		end
		if (match_set) begin
			flags_d[STC_BIT_CMP] = 1'b1;
		end
		if (wrap_now) begin
			flags_d[STC_BIT_OVF] = 1'b1;
		end
	end

	// block lasts until the next tick, even while stopped
	always_comb begin
		block_d = block_q;
		if (timer_tick) begin
			block_d = 1'b0;
		end
		if (count_write) begin
			block_d = 1'b1;
		end
	end

	// temp shared by counter and compare registers
	always_comb begin
		temp_d = temp_q;
		if (wr_count_high || wr_cmp_high) begin
			temp_d = reg_wdata;
		end else if (rd_count_low) begin
			temp_d = count_q[15:8];
		end else if (rd_cmp_low) begin
			temp_d = cmp_q[15:8];
		end
	end

	// ****************************************
	// read mux
	// ****************************************
	// high bytes come from temp so the pair is consistent
	always_comb begin
		rdata_d = STC_RESET_BYTE;
		if (!reg_read) begin
			rdata_d = STC_RESET_BYTE;
		end else if (reg_addr == STC_ADDR_IRQ_FLAGS) begin
			rdata_d = {6'h00, flags_q};
		end else if (reg_addr == STC_ADDR_IRQ_MASK) begin
			rdata_d = {6'h00, mask_q};
		end else if (reg_addr == STC_ADDR_CONTROL_A) begin
			rdata_d = {6'h00, ctrl_a_q};
		end else if (reg_addr == STC_ADDR_CONTROL_B) begin
			rdata_d = {4'h0, ctrl_b_q};
		end else if (reg_addr == STC_ADDR_COUNT_LOW) begin
			rdata_d = count_q[7:0];
		end else if (reg_addr == STC_ADDR_COUNT_HIGH) begin
			rdata_d = temp_q;
		end else if (reg_addr == STC_ADDR_CMP_LOW) begin
			rdata_d = cmp_q[7:0];
		end else if (reg_addr == STC_ADDR_CMP_HIGH) begin
			rdata_d = temp_q;
		end
	end

	// ****************************************
	// state
	// ****************************************
	// control a: low wave mode bits
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ctrl_a_q <= 2'h0;
		end else if (reg_write && (reg_addr == STC_ADDR_CONTROL_A)) begin
			ctrl_a_q <= reg_wdata[1:0];
		end
	end

	// control b: upper bits dropped, software keeps them zero
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ctrl_b_q <= 4'h0;
		end else if (reg_write && (reg_addr == STC_ADDR_CONTROL_B)) begin
			ctrl_b_q <= reg_wdata[3:0];
		end
	end

	// interrupt mask
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mask_q <= 2'h0;
		end else if (reg_write && (reg_addr == STC_ADDR_IRQ_MASK)) begin
			mask_q <= reg_wdata[1:0];
		end
	end

	// compare register loads whole word on low write, takes effect at once
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cmp_q <= STC_RESET_WORD;
		end else if (wr_cmp_low) begin
			cmp_q <= {temp_q, reg_wdata};
		end
	end

	// counter
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			count_q <= STC_RESET_WORD;
		end else begin
			count_q <= count_d;
		end
	end

	// prescaler: free-running, cleared only by resetn, so dividers share one phase
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pre_q <= 10'h000;
		end else begin
			pre_q <= pre_q + 10'h001;
		end
	end

	// match block after a counter write
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			block_q <= 1'b0;
		end else begin
			block_q <= block_d;
		end
	end

	// match delayed one clock into the flag
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			match_q <= 1'b0;
		end else begin
			match_q <= raw_match;
		end
	end

	// interrupt flags
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			flags_q <= 2'h0;
		end else begin
			flags_q <= flags_d;
		end
	end

	// shared temp byte
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			temp_q <= STC_RESET_BYTE;
		end else begin
			temp_q <= temp_d;
		end
	end

	// read data, zero outside the read slot
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= STC_RESET_BYTE;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// compare request, from next flag so it rises with the flag
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cmp_irq_q <= 1'b0;
		end else begin
			cmp_irq_q <= mask_q[STC_BIT_CMP] && global_irq_enable && flags_d[STC_BIT_CMP];
		end
	end

	// overflow request
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ovf_irq_q <= 1'b0;
		end else begin
			ovf_irq_q <= mask_q[STC_BIT_OVF] && global_irq_enable && flags_d[STC_BIT_OVF];
		end
	end

	// match pulse: real match or forced strobe
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fire_q <= 1'b0;
		end else begin
			fire_q <= raw_match || forced_compare_strobe;
		end
	end

	assign reg_rdata           = rdata_q;
	assign cmp_irq             = cmp_irq_q;
	assign ovf_irq             = ovf_irq_q;
	assign compare_match_pulse = fire_q;

endmodule
